// ### core/rislf_pkg.sv
package rislf_pkg;

  // Channel counts: two receive channels (C, D), four rate-range selects (A..D).
  localparam int RX_CH = 2;
  localparam int RATE_CH = 4;

  // Three-level select pin as seen after the level comparator pair.
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // Signalling-rate bounds of each range, in MBd.
  localparam int RATE_LOW_MIN_MBD = 195;
  localparam int RATE_LOW_MAX_MBD = 400;
  localparam int RATE_MID_MAX_MBD = 800;
  localparam int RATE_HIGH_MAX_MBD = 1500;

  typedef enum logic [1:0] {RATE_LOW, RATE_MID, RATE_HIGH} rislf_rate_e;

  // Transition density limit: one transition per this many bits.
  localparam int DENSITY_LIMIT_BITS = 60;
  localparam int DENSITY_CNT_W = 6;

  // Configuration port widths and latch map.
  localparam int CFG_ADDR_W = 4;
  localparam int CFG_DATA_W = 7;
  localparam int CFG_LATCHES = 12;
  localparam logic [3:0] CFG_RXC_ADDR = 4'h0;
  localparam logic [3:0] CFG_RXD_ADDR = 4'h1;
  localparam int CFG_RX_ON_BIT = 0;
  localparam logic [6:0] CFG_RX_INIT = 7'h01;
  localparam logic [6:0] CFG_OTHER_INIT = 7'h00;

  // Register port map.
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h08;
  localparam logic [7:0] REG_LATCH = 8'h0C;

  // Status and mask bit layout.
  localparam int ST_W = 4;
  localparam int ST_FAULT_C = 0;
  localparam int ST_FAULT_D = 1;
  localparam int ST_CFG_WRITE = 2;
  localparam int ST_CFG_UNMAPPED = 3;
  localparam logic [3:0] ST_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // The six conditions that pull a link fault output low.
  typedef struct packed {
    logic rateOut;
    logic ampLow;
    logic densityLow;
    logic chanOff;
    logic localLow;
    logic trainAbsent;
  } rislf_fault_s;

  // One configuration write as taken from the pins.
  typedef struct packed {
    logic [CFG_ADDR_W-1:0] addr;
    logic [CFG_DATA_W-1:0] data;
  } rislf_cfgwr_s;

endpackage : rislf_pkg

// ### core/rislf_sync.sv
`timescale 1ns/100ps

// Two-stage synchroniser for a bundle of independent levels.
module rislf_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_q;

  // A zero-width bundle has nothing to carry, so refuse it at elaboration.
  if (W < 1) begin : g_badWidth
    $error("rislf_sync: width must be at least one");
  end

  // Stage one feeds only stage two; bits may resolve in different cycles.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : rislf_sync

// ### core/rislf_core.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps

module rislf_core
  import rislf_pkg::*;
#(
  parameter int DENSITY_BITS = DENSITY_LIMIT_BITS,
  parameter int NUM_LATCHES = CFG_LATCHES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [RX_CH-1:0] useLocalClockSel,
  input wire logic [RX_CH-1:0] inputPortSelect,
  input wire logic [RX_CH-1:0] primarySerialInput,
  input wire logic [RX_CH-1:0] secondarySerialInput,
  input wire logic [RX_CH-1:0] trainingClockPresent,
  input wire logic [RX_CH-1:0] amplitudeLow,
  input wire logic [RX_CH-1:0] rateOutOfRange,
  input wire logic detectorGateEnable,
  input wire logic [2*RATE_CH-1:0] rateRangeSelect,
  input wire logic configWriteStrobeN,
  input wire logic [CFG_ADDR_W-1:0] configAddr,
  input wire logic [CFG_DATA_W-1:0] configData,
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  output logic [RX_CH-1:0] cdrSerialIn,
  output logic [RX_CH-1:0] receivePllFollowsTraining,
  output logic [RX_CH-1:0] linkFaultN,
  output rislf_rate_e [1:0] txPllRange,
  output rislf_rate_e [1:0] rxPllRange,
  output logic [RX_CH-1:0] rxPowerOn,
  output logic irq
);

  localparam int SYNC_W = 7 * RX_CH + 1 + 2 * RATE_CH + 1 + CFG_ADDR_W + CFG_DATA_W;

  // Refuse sizes that the six-bit run counter or the four-bit latch address cannot serve.
  if (DENSITY_BITS < 2 || DENSITY_BITS > 63) begin : g_badDensity
    $error("rislf_core: density limit must lie in 2..63");
  end
  if (NUM_LATCHES < 2 || NUM_LATCHES > 16) begin : g_badLatches
    $error("rislf_core: latch count must lie in 2..16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.
  logic [RX_CH-1:0] ulcS, selS, priS, secS, trgS, ampS, rngS;
  logic gateS, strobeS;
  logic [2*RATE_CH-1:0] rateS;
  rislf_cfgwr_s cfgS;

  // Every pin here is asynchronous to sys_clk; the strobe crosses inverted so that reset reads idle.
  rislf_sync #(
    .W(SYNC_W)
  ) u_pinSync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .asyncIn({useLocalClockSel, inputPortSelect, primarySerialInput,
      secondarySerialInput, trainingClockPresent, amplitudeLow,
      rateOutOfRange, detectorGateEnable, rateRangeSelect,
      ~configWriteStrobeN, configAddr, configData}),
    .syncOut({ulcS, selS, priS, secS, trgS, ampS, rngS, gateS, rateS,
      strobeS, cfgS})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  // Decode a three-level select; a floating pin self-biases to mid.
  function automatic rislf_rate_e decodeLevel(input logic [1:0] lvl);
    rislf_rate_e r;
    r = RATE_MID;
    case (lvl)
      LVL_LOW: r = RATE_LOW;
      LVL_HIGH: r = RATE_HIGH;
      default: r = RATE_MID;
    endcase
    return r;
  endfunction : decodeLevel

  // Initial value of each configuration latch.
  function automatic logic [CFG_DATA_W-1:0] latchInit(input int idx);
    logic [CFG_DATA_W-1:0] v;
    v = CFG_OTHER_INIT;
    if (idx == int'(CFG_RXC_ADDR) || idx == int'(CFG_RXD_ADDR)) begin
      v = CFG_RX_INIT;
    end
    return v;
  endfunction : latchInit

  ////////////////////////////////////////////////////////////////////////////
  // Configuration latches.
  logic [CFG_DATA_W-1:0] latch_q [NUM_LATCHES];
  logic strobePrev_q;
  logic cfgMapped;
  logic cfgWriteStart;

  assign cfgMapped = int'(cfgS.addr) < NUM_LATCHES;
  assign cfgWriteStart = !strobePrev_q && strobeS;

  // Level-sensitive capture while the strobe is low, like a transparent latch.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NUM_LATCHES; i++) begin
      if (!rst_n) begin
        latch_q[i] <= latchInit(i);
      end else if (strobeS && int'(cfgS.addr) == i) begin
        latch_q[i] <= cfgS.data;
      end
    end
  end

  // Strobe history; reset equals the idle level, so no false write follows a reset release.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strobePrev_q <= 1'b0;
    end else begin
      strobePrev_q <= strobeS;
    end
  end

  // The channel enable bit comes from each channel's own latch.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxPowerOn <= '0;
    end else begin
      rxPowerOn[0] <= latch_q[CFG_RXC_ADDR][CFG_RX_ON_BIT];
      rxPowerOn[1] <= latch_q[CFG_RXD_ADDR][CFG_RX_ON_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate ranges.
  // Each select reaches only its own PLL.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txPllRange <= '{RATE_MID, RATE_MID};
      rxPllRange <= '{RATE_MID, RATE_MID};
    end else begin
      txPllRange[0] <= decodeLevel(rateS[1:0]);
      txPllRange[1] <= decodeLevel(rateS[3:2]);
      rxPllRange[0] <= decodeLevel(rateS[5:4]);
      rxPllRange[1] <= decodeLevel(rateS[7:6]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input selection and transition density.
  logic [RX_CH-1:0] selBit;
  logic [RX_CH-1:0] selPrev_q;
  logic [RX_CH-1:0] bitPrev_q;
  logic [DENSITY_CNT_W-1:0] runLen_q [RX_CH];
  logic [RX_CH-1:0] densityLow;

  // Primary when the select is high, secondary when low.
  assign selBit = (selS & priS) | (~selS & secS);

  // Drive the chosen stream into the recovery path.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cdrSerialIn <= '0;
    end else begin
      cdrSerialIn <= selBit;
    end
  end

  // Count bits since the last transition; a port change restarts the run
  // so a stale count from the old stream cannot raise a false fault.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      selPrev_q <= '0;
      bitPrev_q <= '0;
      for (int c = 0; c < RX_CH; c++) begin
        runLen_q[c] <= '0;
      end
    end else begin
      selPrev_q <= selS;
      bitPrev_q <= selBit;
      for (int c = 0; c < RX_CH; c++) begin
        if (selBit[c] != bitPrev_q[c] || selS[c] != selPrev_q[c]) begin
          runLen_q[c] <= '0;
        end else if (runLen_q[c] != DENSITY_CNT_W'(DENSITY_BITS)) begin
          runLen_q[c] <= runLen_q[c] + 1'b1;
        end
      end
    end
  end

  // One transition per limit bits; a full run without one is too sparse.
  always_comb begin
    for (int c = 0; c < RX_CH; c++) begin
      densityLow[c] = runLen_q[c] == DENSITY_CNT_W'(DENSITY_BITS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault conditions and PLL reference choice.
  rislf_fault_s [RX_CH-1:0] fault;
  logic [RX_CH-1:0] followTrain;
  logic [RX_CH-1:0] anyFault;

  // Gather the six conditions per channel.
  always_comb begin
    for (int c = 0; c < RX_CH; c++) begin
      fault[c].rateOut = rngS[c];
      fault[c].ampLow = ampS[c];
      fault[c].densityLow = densityLow[c];
      fault[c].chanOff = !rxPowerOn[c];
      fault[c].localLow = !ulcS[c];
      fault[c].trainAbsent = !trgS[c];
      anyFault[c] = |fault[c];
      // With the gate low only the local clock select and the range check decide the reference.
      if (!ulcS[c]) begin
        followTrain[c] = 1'b1;
      end else if (gateS) begin
        followTrain[c] = rngS[c] | ampS[c] | densityLow[c];
      end else begin
        followTrain[c] = rngS[c];
      end
    end
  end

  // Register the PLL reference choice and the fault outputs.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      receivePllFollowsTraining <= '1;
      linkFaultN <= '0;
    end else begin
      receivePllFollowsTraining <= followTrain;
      linkFaultN <= ~anyFault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, mask and interrupt.
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] events;
  logic [ST_W-1:0] clearBits;

  // Fault onset is the output going low; also config writes and stray ones.
  always_comb begin
    events = '0;
    events[ST_FAULT_C] = linkFaultN[0] && anyFault[0];
    events[ST_FAULT_D] = linkFaultN[1] && anyFault[1];
    events[ST_CFG_WRITE] = cfgWriteStart && cfgMapped;
    events[ST_CFG_UNMAPPED] = cfgWriteStart && !cfgMapped;
    clearBits = '0;
    if (regWrite && regAddr == REG_STATUS) begin
      clearBits = regWrData[ST_W-1:0];
    end
  end

  // Write-one-to-clear; a new event in the same cycle keeps its bit set.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_q <= ST_RESET;
    end else begin
      status_q <= (status_q & ~clearBits) | events;
    end
  end

  // Mask register: a one lets the bit reach the interrupt.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mask_q <= MASK_RESET;
    end else if (regWrite && regAddr == REG_MASK) begin
      mask_q <= regWrData[ST_W-1:0];
    end
  end

  // Registered interrupt lags the status by one cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port.
  logic [CFG_ADDR_W-1:0] latchSel_q;
  logic [31:0] rdNext;

  // Latch selector for readback of one configuration latch.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      latchSel_q <= '0;
    end else if (regWrite && regAddr == REG_LATCH) begin
      latchSel_q <= regWrData[CFG_ADDR_W-1:0];
    end
  end

  // Unmapped addresses read as zero.
  always_comb begin
    rdNext = '0;
    case (regAddr)
      REG_STATUS: rdNext[ST_W-1:0] = status_q;
      REG_MASK: rdNext[ST_W-1:0] = mask_q;
      REG_STATE: rdNext = {16'h0000, linkFaultN, receivePllFollowsTraining,
        fault[1], fault[0]};
      REG_LATCH: begin
        rdNext[11:8] = latchSel_q;
        if (int'(latchSel_q) < NUM_LATCHES) begin
          rdNext[CFG_DATA_W-1:0] = latch_q[latchSel_q];
        end
      end
      default: rdNext = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else if (regRead) begin
      regRdData <= rdNext;
    end else begin
      regRdData <= '0;
    end
  end

endmodule : rislf_core

// ### sim/rislf_props.sv
`timescale 1ns/100ps

// Checker on the top ports; all properties share one clock and one reset.
module rislf_props
  import rislf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [RX_CH-1:0] useLocalClockSel,
  input wire logic [RX_CH-1:0] inputPortSelect,
  input wire logic [RX_CH-1:0] primarySerialInput,
  input wire logic [RX_CH-1:0] secondarySerialInput,
  input wire logic [RX_CH-1:0] trainingClockPresent,
  input wire logic [RX_CH-1:0] amplitudeLow,
  input wire logic [RX_CH-1:0] rateOutOfRange,
  input wire logic detectorGateEnable,
  input wire logic [2*RATE_CH-1:0] rateRangeSelect,
  input wire logic configWriteStrobeN,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic [RX_CH-1:0] cdrSerialIn,
  input wire logic [RX_CH-1:0] receivePllFollowsTraining,
  input wire logic [RX_CH-1:0] linkFaultN,
  input wire rislf_rate_e [1:0] rxPllRange,
  input wire logic [RX_CH-1:0] rxPowerOn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Counts edges since reset release, so that synchroniser flush is not judged.
  logic [2:0] upCnt_q;
  logic settled;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) upCnt_q <= 3'h0;
    else if (upCnt_q != 3'h7) upCnt_q <= upCnt_q + 3'h1;
  end
  assign settled = (upCnt_q == 3'h7);

  ////////////////////////////////////////////////////////////////////////////
  chk_ulc_fault: assert property ((!useLocalClockSel[0])[*5]
    |-> !linkFaultN[0] && receivePllFollowsTraining[0]) else $error("local clock low without fault");
  chk_train_fault: assert property ((!trainingClockPresent[1])[*5] |-> !linkFaultN[1])
    else $error("missing training clock without fault");
  chk_gate_amp: assert property ((detectorGateEnable && amplitudeLow[0])[*5]
    |-> receivePllFollowsTraining[0]) else $error("low amplitude not followed");
  chk_rate_follow: assert property (rateOutOfRange[1][*5]
    |-> receivePllFollowsTraining[1] && !linkFaultN[1]) else $error("rate fault not followed");
  chk_gate_off: assert property ((settled && !detectorGateEnable && useLocalClockSel[0]
    && !rateOutOfRange[0])[*5] |-> !receivePllFollowsTraining[0]) else $error("follow with gate low");
  chk_sel_pri: assert property ((settled && inputPortSelect[1] && primarySerialInput[1])[*5]
    |-> cdrSerialIn[1]) else $error("primary input not routed");
  chk_sel_sec: assert property ((settled && !inputPortSelect[0] && !secondarySerialInput[0])[*5]
    |-> !cdrSerialIn[0]) else $error("secondary input not routed");
  chk_rd_idle: assert property (regRdData != 32'h0 |-> $past(regRead)) else $error("read data unasked");
  chk_range_c: assert property ((settled && rateRangeSelect[5:4] == 2'h2)[*5]
    |-> rxPllRange[0] == RATE_HIGH) else $error("range C not high");
  chk_cfg_quiet: assert property ((settled && configWriteStrobeN)[*8]
    |-> $stable(rxPowerOn)) else $error("latch moved without strobe");
endmodule : rislf_props

bind rislf_core rislf_props chk (.sys_clk(sys_clk), .rst_n(rst_n), .useLocalClockSel(useLocalClockSel),
  .inputPortSelect(inputPortSelect), .primarySerialInput(primarySerialInput),
  .secondarySerialInput(secondarySerialInput), .trainingClockPresent(trainingClockPresent),
  .amplitudeLow(amplitudeLow), .rateOutOfRange(rateOutOfRange), .detectorGateEnable(detectorGateEnable),
  .rateRangeSelect(rateRangeSelect), .configWriteStrobeN(configWriteStrobeN), .regRead(regRead),
  .regRdData(regRdData), .cdrSerialIn(cdrSerialIn), .receivePllFollowsTraining(receivePllFollowsTraining),
  .linkFaultN(linkFaultN), .rxPllRange(rxPllRange), .rxPowerOn(rxPowerOn));

// ### sim/rislf_line_src.sv
`timescale 1ns/100ps

// Serial line sources; a quiet channel holds primary high and secondary low.
module rislf_line_src (
  input wire logic sys_clk,
  input wire logic [1:0] quiet,
  output logic [1:0] primary,
  output logic [1:0] secondary
);
  logic [1:0] phase_q;

  // Running lines toggle every one or two bits, far above the density floor.
  initial begin
    phase_q = 2'h0;
    primary = 2'h0;
    secondary = 2'h0;
  end
  always @(posedge sys_clk) begin
    phase_q <= phase_q + 2'h1;
    for (int i = 0; i < 2; i++) begin
      primary[i] <= quiet[i] | phase_q[0];
      secondary[i] <= !quiet[i] & phase_q[1];
    end
  end
endmodule : rislf_line_src

// ### sim/test_rislf_core.sv
`timescale 1ns/100ps

module test_rislf_core
  import rislf_pkg::*;
();
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] ulc = 2'h3, ips = 2'h3, train = 2'h3, amp = 2'h0, rof = 2'h0, quiet = 2'h0;
  logic gate = 1'b1, cfgN = 1'b1, rw = 1'b0, rr = 1'b0;
  logic [7:0] rrs = 8'h55, regAddr = 8'h00;
  logic [3:0] cAddr = 4'h0;
  logic [6:0] cData = 7'h00, d;
  logic [31:0] wd = 32'h0, regRdData;
  logic [1:0] cdr, fol, lfn, pwr, pri, sec;
  rislf_rate_e [1:0] txr, rxr;
  logic irq;
  int n_mismatch = 0, comparisons = 0, cyc = 0, ch;

  // Short density count keeps the quiet-line cases brief.
  rislf_core #(.DENSITY_BITS(8)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .useLocalClockSel(ulc),
    .inputPortSelect(ips), .primarySerialInput(pri), .secondarySerialInput(sec), .trainingClockPresent(train),
    .amplitudeLow(amp), .rateOutOfRange(rof), .detectorGateEnable(gate), .rateRangeSelect(rrs),
    .configWriteStrobeN(cfgN), .configAddr(cAddr), .configData(cData), .regAddr(regAddr), .regWrData(wd),
    .regWrite(rw), .regRead(rr), .regRdData(regRdData), .cdrSerialIn(cdr), .receivePllFollowsTraining(fol),
    .linkFaultN(lfn), .txPllRange(txr), .rxPllRange(rxr), .rxPowerOn(pwr), .irq(irq));
  rislf_line_src src (.sys_clk(sys_clk), .quiet(quiet), .primary(pri), .secondary(sec));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and the hang guard.
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    wd <= v;
    rw <= 1'b1;
    @(posedge sys_clk);
    rw <= 1'b0;
  endtask : reg_wr
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    rr <= 1'b1;
    @(posedge sys_clk);
    rr <= 1'b0;
    #1 chk(nm, e, regRdData);
  endtask : rd_chk
  task automatic latch_chk(input logic [3:0] s, input logic [6:0] e);
    reg_wr(REG_LATCH, {28'h0, s});
    rd_chk("latch", REG_LATCH, {20'h0, s, 1'b0, e});
  endtask : latch_chk
  // Address and data settle three cycles before the strobe and hold while it is low.
  task automatic cfg_wr(input logic [3:0] a, input logic [6:0] v);
    @(posedge sys_clk);
    cAddr <= a;
    cData <= v;
    tick(3);
    cfgN <= 1'b0;
    tick(3);
    cfgN <= 1'b1;
    tick(6);
  endtask : cfg_wr
  function automatic rislf_rate_e exp_rate(input logic [1:0] c);
    return (c == 2'h0) ? RATE_LOW : (c == 2'h2) ? RATE_HIGH : RATE_MID;
  endfunction : exp_rate
  // State word: one fault bit for scenario k on channel c, that channel's fault output low.
  function automatic logic [31:0] exp_state(input int k, input int c);
    logic [1:0] f;
    f = (k < 3 || k == 4) ? 2'(1 << c) : 2'h0;
    return {16'h0000, 2'h3 ^ 2'(1 << c), f, 12'(1 << (6 * c + 5 - k))};
  endfunction : exp_state
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(21461));
    tick(5);
    rst_n <= 1'b1;
    #1 chk("lfn", 32'h0, lfn);
    chk("fol", 32'h3, fol);
    latch_chk(4'h0, CFG_RX_INIT);
    latch_chk(4'h7, CFG_OTHER_INIT);
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk);
      rrs <= {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)};
      tick(6);
      for (int i = 0; i < 4; i++) begin
        #1 chk("range", exp_rate(2'(c + i)), (i < 2) ? txr[i % 2] : rxr[i % 2]);
      end
    end
    tick(10);
    #1 chk("lfn", 32'h3, lfn);
    chk("fol", 32'h0, fol);
    rd_chk("state", REG_STATE, 32'h0000_C000);
    // Each fault condition alone, on a random channel, then released.
    for (int k = 0; k < 6; k++) begin
      ch = $urandom % 2;
      @(posedge sys_clk);
      case (k)
        0: rof[ch] <= 1'b1;
        1: amp[ch] <= 1'b1;
        2: quiet[ch] <= 1'b1;
        4: ulc[ch] <= 1'b0;
        5: train[ch] <= 1'b0;
        default: cfg_wr(4'(ch), 7'h00);
      endcase
      tick(20);
      #1 chk("lfn", 32'h3 ^ (32'h1 << ch), lfn);
      chk("pwr", (k == 3) ? 32'h3 ^ (32'h1 << ch) : 32'h3, pwr);
      if (k < 3 || k == 4) chk("fol", 32'h1, fol[ch]);
      rd_chk("state", REG_STATE, exp_state(k, ch));
      if (k == 1) begin
        @(posedge sys_clk);
        gate <= 1'b0;
        tick(8);
        #1 chk("fol", 32'h0, fol[ch]);
      end
      @(posedge sys_clk);
      {rof, amp, quiet, ulc, train, gate} <= 11'h01F;
      if (k == 3) cfg_wr(4'(ch), CFG_RX_INIT);
      tick(20);
    end
    @(posedge sys_clk);
    quiet <= 2'h3;
    repeat (4) begin
      @(posedge sys_clk);
      ips <= 2'($urandom);
      tick(6);
      #1 chk("cdr", ips, cdr);
    end
    @(posedge sys_clk);
    quiet <= 2'h0;
    tick(20);
    // Event status, mask and interrupt around configuration writes.
    reg_wr(REG_STATUS, 32'hF);
    rd_chk("status", REG_STATUS, 32'h0);
    reg_wr(REG_MASK, 32'h4);
    rd_chk("mask", REG_MASK, 32'h4);
    d = 7'($urandom);
    cfg_wr(4'h5, d);
    #1 chk("irq", 32'h1, irq);
    latch_chk(4'h5, d);
    cfg_wr(4'hC, 7'h7F);
    rd_chk("status", REG_STATUS, 32'hC);
    latch_chk(4'h0, CFG_RX_INIT);
    latch_chk(4'h5, d);
    reg_wr(REG_STATUS, 32'hF);
    tick(2);
    #1 chk("irq", 32'h0, irq);
    reg_wr(REG_MASK, 32'h0);
    cfg_wr(4'h2, 7'h11);
    #1 chk("irq", 32'h0, irq);
    rd_chk("status", REG_STATUS, 32'h4);
    rd_chk("unmapped", 8'h40, 32'h0);
    // A second reset in mid-run must bring the latches back.
    @(posedge sys_clk);
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    latch_chk(4'h5, CFG_OTHER_INIT);
    end_sim();
  end
endmodule : test_rislf_core
